// *** include/fbep_consts.svh ***
// constants for the flash block erase and protection checker
// Summary of operation
// - 64 KB flash in 1 KB blocks, each erased alone, others untouched.
// - erasing a block sets every bit of that block to one.
// - one protection attribute per 2 KB region covering two adjacent blocks.
// - read-only regions refuse erase and program, contents stay unaltered.
// - execute-only regions also refuse erase and program.
// - execute-only regions return data to fetches only, deny data and debug reads.
`ifndef FBEP_CONSTS_SVH
`define FBEP_CONSTS_SVH

// ****************************************
// array geometry
// ****************************************
`define FBEP_ADDR_W 16
`define FBEP_WADDR_W 14
`define FBEP_DATA_W 32
`define FBEP_BLK_LSB 10
`define FBEP_BLK_W 6
`define FBEP_REG_LSB 11
`define FBEP_REG_W 5
`define FBEP_NREG 32
`define FBEP_WCNT_W 8
`define FBEP_WCNT_LAST 8'hFF
`define FBEP_ERASED 32'hFFFF_FFFF

// ****************************************
// protection attribute codes
// ****************************************
`define FBEP_ATTR_W 2
`define FBEP_ATTR_OPEN 2'h0
`define FBEP_ATTR_RO 2'h1
`define FBEP_ATTR_XO 2'h2
`define FBEP_ATTR_RST 2'h0

`endif

// *** include/fbep_pkg.sv ***
// types and decode functions for the flash protection checker
`include "fbep_consts.svh"

package fbep_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef logic [`FBEP_ATTR_W-1:0] fbep_attr_t;
   typedef logic [`FBEP_ADDR_W-1:0] fbep_addr_t;
   typedef logic [`FBEP_DATA_W-1:0] fbep_data_t;
   typedef logic [`FBEP_REG_W-1:0] fbep_region_t;

   typedef enum logic [1:0] {
      FBEP_OP_FETCH = 2'h0,
      FBEP_OP_READ = 2'h1,
      FBEP_OP_PROG = 2'h2,
      FBEP_OP_ERASE = 2'h3
   } fbep_op_e;

   typedef enum logic [3:0] {
      FBEP_ST_IDLE = 4'b0001,
      FBEP_ST_CHECK = 4'b0010,
      FBEP_ST_XFER = 4'b0100,
      FBEP_ST_ERASE = 4'b1000
   } fbep_state_e;

   // ****************************************
   // protection decode
   // ****************************************
   // any code other than open forbids modification; 2'h3 is read as execute-only
   function automatic logic fbep_write_locked(input fbep_attr_t attr);
      return attr != `FBEP_ATTR_OPEN;
   endfunction : fbep_write_locked

   // only execute-style codes hide contents from data reads
   function automatic logic fbep_read_locked(input fbep_attr_t attr);
      return attr[1];
   endfunction : fbep_read_locked

endpackage : fbep_pkg

// *** include/fbep_attr_if.sv ***
// carrier between the checker and its attribute table
`timescale 1ns/1ps

interface fbep_attr_if;
   import fbep_pkg::*;
   logic wr_en;
   fbep_region_t wr_region;
   fbep_attr_t wr_attr;
   fbep_region_t rd_region;
   fbep_attr_t rd_attr;

   modport ctrl (output wr_en, output wr_region, output wr_attr, output rd_region,
      input rd_attr);
   modport mem (input wr_en, input wr_region, input wr_attr, input rd_region,
      output rd_attr);
endinterface : fbep_attr_if

// *** hdl/fbep_attr_mem.sv ***
// per-region protection attribute table with registered read
`timescale 1ns/1ps
`include "fbep_consts.svh"

module fbep_attr_mem (
   input wire logic core_clk,
   input wire logic rst_n,
   fbep_attr_if.mem port
);
   import fbep_pkg::*;

   fbep_attr_t table_q [`FBEP_NREG];

   // ****************************************
   // storage, one attribute per 2 KB region
   // ****************************************
   for (genvar g = 0; g < `FBEP_NREG; g++) begin : g_entry
      // each entry owns its write decode
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            table_q[g] <= `FBEP_ATTR_RST;
         end else if (port.wr_en && port.wr_region == `FBEP_REG_W'(g)) begin
            table_q[g] <= port.wr_attr;
         end
      end
   end

   // read data registered; the checker spends one cycle waiting for it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         port.rd_attr <= `FBEP_ATTR_RST;
      end else begin
         port.rd_attr <= table_q[port.rd_region];
      end
   end

endmodule : fbep_attr_mem

// *** hdl/fbep_top.sv ***
// flash access checker: erase, program, read and fetch under region protection
`timescale 1ns/1ps
`include "fbep_consts.svh"

module fbep_top (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic if_req,
   input wire fbep_pkg::fbep_addr_t if_addr,
   output logic if_gnt,
   input wire logic d_req,
   input wire logic d_write,
   input wire logic d_debug,
   input wire fbep_pkg::fbep_addr_t d_addr,
   input wire fbep_pkg::fbep_data_t d_wdata,
   output logic d_gnt,
   input wire logic er_req,
   input wire logic [`FBEP_BLK_W-1:0] er_block,
   output logic er_gnt,
   input wire logic prot_we,
   input wire fbep_pkg::fbep_region_t prot_region,
   input wire fbep_pkg::fbep_attr_t prot_attr,
   output logic rsp_valid,
   output logic rsp_denied,
   output fbep_pkg::fbep_op_e rsp_op,
   output fbep_pkg::fbep_data_t rsp_rdata,
   output logic fl_re,
   output logic fl_we,
   output logic [`FBEP_WADDR_W-1:0] fl_addr,
   output fbep_pkg::fbep_data_t fl_wdata,
   input wire fbep_pkg::fbep_data_t fl_rdata,
   output logic viol,
   input wire logic viol_clr
);
   import fbep_pkg::*;

   logic rst_meta;
   logic rst_n;
   fbep_state_e state;
   fbep_op_e op;
   fbep_addr_t op_addr;
   fbep_data_t op_wdata;
   logic op_debug;
   logic [`FBEP_WCNT_W-1:0] wcnt;
   logic deny;
   logic any_gnt;

   fbep_attr_if attr_bus ();

   // ****************************************
   // reset release
   // ****************************************
   // deassertion re-timed so no flop sees a release near the edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************
   // arbitration, fetch first so code never starves
   // ****************************************
   assign if_gnt = (state == FBEP_ST_IDLE) && if_req;
   assign d_gnt = (state == FBEP_ST_IDLE) && d_req && !if_req;
   assign er_gnt = (state == FBEP_ST_IDLE) && er_req && !if_req && !d_req;
   assign any_gnt = if_gnt || d_gnt || er_gnt;

   // attribute lookup uses the pair index of the block
   assign attr_bus.wr_en = prot_we;
   assign attr_bus.wr_region = prot_region;
   assign attr_bus.wr_attr = prot_attr;
   always_comb begin
      if (if_gnt) begin
         attr_bus.rd_region = if_addr[`FBEP_REG_LSB +: `FBEP_REG_W];
      end else if (d_gnt) begin
         attr_bus.rd_region = d_addr[`FBEP_REG_LSB +: `FBEP_REG_W];
      end else begin
         attr_bus.rd_region = er_block[`FBEP_BLK_W-1:1];
      end
   end

   fbep_attr_mem u_attr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .port(attr_bus.mem)
   );

   // ****************************************
   // protection decision in the check cycle
   // ****************************************
   always_comb begin
      unique case (op)
         FBEP_OP_FETCH: deny = 1'b0;
         FBEP_OP_READ: deny = fbep_read_locked(attr_bus.rd_attr);
         FBEP_OP_PROG: deny = fbep_write_locked(attr_bus.rd_attr);
         FBEP_OP_ERASE: deny = fbep_write_locked(attr_bus.rd_attr);
      endcase
   end

   // ****************************************
   // request capture
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op <= FBEP_OP_FETCH;
         op_addr <= '0;
         op_wdata <= '0;
         op_debug <= 1'b0;
      end else if (if_gnt) begin
         op <= FBEP_OP_FETCH;
         op_addr <= if_addr;
         op_debug <= 1'b0;
      end else if (d_gnt) begin
         op <= d_write ? FBEP_OP_PROG : FBEP_OP_READ;
         op_addr <= d_addr;
         op_wdata <= d_wdata;
         op_debug <= d_debug;
      end else if (er_gnt) begin
         op <= FBEP_OP_ERASE;
         op_addr <= {er_block, `FBEP_BLK_LSB'(0)};
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= FBEP_ST_IDLE;
      end else begin
         unique case (state)
            FBEP_ST_IDLE: if (any_gnt) state <= FBEP_ST_CHECK;
            FBEP_ST_CHECK: begin
               if (deny) begin
                  state <= FBEP_ST_IDLE;
               end else if (op == FBEP_OP_ERASE) begin
                  state <= FBEP_ST_ERASE;
               end else begin
                  state <= FBEP_ST_XFER;
               end
            end
            FBEP_ST_XFER: state <= FBEP_ST_IDLE;
            FBEP_ST_ERASE: if (wcnt == `FBEP_WCNT_LAST) state <= FBEP_ST_IDLE;
            default: state <= FBEP_ST_IDLE;
         endcase
      end
   end

   // word walk through one 1 KB block only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wcnt <= '0;
      end else if (state == FBEP_ST_ERASE) begin
         wcnt <= wcnt + `FBEP_WCNT_W'(1);
      end else begin
         wcnt <= '0;
      end
   end

   // ****************************************
   // flash array drive, registered
   // ****************************************
   // a refused op never raises a strobe, so the array is untouched
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fl_re <= 1'b0;
         fl_we <= 1'b0;
         fl_addr <= '0;
         fl_wdata <= '0;
      end else if (state == FBEP_ST_CHECK && !deny) begin
         fl_re <= (op == FBEP_OP_FETCH) || (op == FBEP_OP_READ);
         fl_we <= (op == FBEP_OP_PROG) || (op == FBEP_OP_ERASE);
         fl_addr <= op_addr[`FBEP_ADDR_W-1:2];
         fl_wdata <= (op == FBEP_OP_ERASE) ? `FBEP_ERASED : op_wdata;
      end else if (state == FBEP_ST_ERASE && wcnt != `FBEP_WCNT_LAST) begin
         fl_addr <= {op_addr[`FBEP_BLK_LSB +: `FBEP_BLK_W], wcnt + `FBEP_WCNT_W'(1)};
      end else begin
         fl_re <= 1'b0;
         fl_we <= 1'b0;
      end
   end

   // ****************************************
   // response and violation flag
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_denied <= 1'b0;
         rsp_op <= FBEP_OP_FETCH;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= (state == FBEP_ST_CHECK && deny) || state == FBEP_ST_XFER ||
            (state == FBEP_ST_ERASE && wcnt == `FBEP_WCNT_LAST);
         rsp_denied <= state == FBEP_ST_CHECK && deny;
         rsp_op <= op;
         // hidden contents read back as zero, never the array word
         rsp_rdata <= (state == FBEP_ST_XFER && fl_re) ? fl_rdata : '0;
      end
   end

   // set wins over software clear so no refusal is lost
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         viol <= 1'b0;
      end else if (state == FBEP_ST_CHECK && deny) begin
         viol <= 1'b1;
      end else if (viol_clr) begin
         viol <= 1'b0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_erase_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
      fl_we && state == FBEP_ST_ERASE |-> fl_wdata == `FBEP_ERASED)
      else $error("erase wrote a word that is not all ones");
   a_erase_one_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_ERASE |-> fl_we &&
      fl_addr[`FBEP_WADDR_W-1 -: `FBEP_BLK_W] == op_addr[`FBEP_BLK_LSB +: `FBEP_BLK_W])
      else $error("erase strayed outside its block");
   a_erase_end: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state == FBEP_ST_ERASE) |-> ##255 (wcnt == `FBEP_WCNT_LAST) ##1
      (rsp_valid && !rsp_denied && state == FBEP_ST_IDLE))
      else $error("erase did not cover exactly 256 words");
   a_pair_lookup: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_CHECK |-> $past(attr_bus.rd_region) == op_addr[`FBEP_REG_LSB +: `FBEP_REG_W])
      else $error("attribute taken from the wrong region");
   a_ro_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_CHECK && attr_bus.rd_attr == `FBEP_ATTR_RO && op inside {FBEP_OP_PROG,
      FBEP_OP_ERASE} |=> !fl_we && rsp_valid && rsp_denied ##1 !fl_we)
      else $error("read-only region was modified");
   a_xo_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_CHECK && attr_bus.rd_attr == `FBEP_ATTR_XO && op != FBEP_OP_FETCH &&
      op != FBEP_OP_READ |=> !fl_we && rsp_denied)
      else $error("execute-only region was modified");
   a_xo_hide_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_CHECK && attr_bus.rd_attr == `FBEP_ATTR_XO && op == FBEP_OP_READ
      |=> !fl_re && rsp_denied && rsp_rdata == '0)
      else $error("execute-only contents leaked to a data read");
   a_fetch_served: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == FBEP_ST_CHECK && op == FBEP_OP_FETCH |=> fl_re ##1 rsp_valid && !rsp_denied)
      else $error("instruction fetch was not served");
   a_viol_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid && rsp_denied |-> viol)
      else $error("refusal did not raise the violation flag");
   a_viol_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
      viol && !viol_clr |=> viol)
      else $error("violation flag dropped without a clear");

   c_erase_done: cover property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid && rsp_op == FBEP_OP_ERASE && !rsp_denied);
   c_prog_denied: cover property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid && rsp_op == FBEP_OP_PROG && rsp_denied);
   c_read_denied: cover property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid && rsp_op == FBEP_OP_READ && rsp_denied && op_debug);
   c_fetch_ok: cover property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid && rsp_op == FBEP_OP_FETCH);

endmodule : fbep_top

// *** tb/fbep_flash_model.sv ***
// behavioural flash array on the far side of the protection checker
`timescale 1ns/1ps
`include "fbep_consts.svh"

module fbep_flash_model (
   input wire logic core_clk,
   input wire logic fl_re,
   input wire logic fl_we,
   input wire logic [`FBEP_WADDR_W-1:0] fl_addr,
   input wire fbep_pkg::fbep_data_t fl_wdata,
   output fbep_pkg::fbep_data_t fl_rdata
);
   import fbep_pkg::*;
   fbep_data_t mem [0:16383];
   fbep_data_t last;
   int writes = 0;

   // ****************************************
   // storage
   // ****************************************
   // known pattern per word so that reads show which word came back
   initial begin
      for (int i = 0; i < 16384; i++) begin
         mem[i] = 32'h5A5A_0000 | i;
      end
      last = 32'h0000_0000;
   end

   // write port; the count lets the bench check erase length
   always @(posedge core_clk) begin
      if (fl_we) begin
         mem[fl_addr] <= fl_wdata;
         writes <= writes + 1;
      end
      if (fl_re) begin
         last <= mem[fl_addr];
      end
   end

   // outside a read strobe the bus shows junk, never the last word
   assign fl_rdata = fl_re ? mem[fl_addr] : ~last;
endmodule : fbep_flash_model

// *** tb/tb.sv ***
// self-checking bench for the flash protection checker
`timescale 1ns/1ps
`include "fbep_consts.svh"

module tb;
   import fbep_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic if_req = 1'b0;
   fbep_addr_t if_addr = 16'h0000;
   logic d_req = 1'b0;
   logic d_write = 1'b0;
   logic d_debug = 1'b0;
   fbep_addr_t d_addr = 16'h0000;
   fbep_data_t d_wdata = 32'h0000_0000;
   logic er_req = 1'b0;
   logic [`FBEP_BLK_W-1:0] er_block = 6'h00;
   logic prot_we = 1'b0;
   fbep_region_t prot_region = 5'h00;
   fbep_attr_t prot_attr = 2'h0;
   logic viol_clr = 1'b0;
   logic if_gnt, d_gnt, er_gnt, rsp_valid, rsp_denied, fl_re, fl_we, viol;
   fbep_op_e rsp_op;
   fbep_data_t rsp_rdata, fl_wdata, fl_rdata;
   logic [`FBEP_WADDR_W-1:0] fl_addr;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;

   // ****************************************
   // clock, instances, timeout
   // ****************************************
   always #2.5 core_clk = ~core_clk;

   fbep_top dut (.core_clk(core_clk), .arst_n(arst_n), .if_req(if_req), .if_addr(if_addr),
      .if_gnt(if_gnt), .d_req(d_req), .d_write(d_write), .d_debug(d_debug), .d_addr(d_addr),
      .d_wdata(d_wdata), .d_gnt(d_gnt), .er_req(er_req), .er_block(er_block),
      .er_gnt(er_gnt), .prot_we(prot_we), .prot_region(prot_region), .prot_attr(prot_attr),
      .rsp_valid(rsp_valid), .rsp_denied(rsp_denied), .rsp_op(rsp_op),
      .rsp_rdata(rsp_rdata), .fl_re(fl_re), .fl_we(fl_we), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .viol(viol), .viol_clr(viol_clr));

   fbep_flash_model flash (.core_clk(core_clk), .fl_re(fl_re), .fl_we(fl_we),
      .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));

   // whole run needs about 400 cycles; the ceiling leaves slack
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         end_sim();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // word pattern that the array model holds before any write
   function automatic fbep_data_t pat(input fbep_addr_t a);
      return 32'h5A5A_0000 | {18'h0_0000, a[15:2]};
   endfunction : pat

   // kind: 0 fetch, 1 read, 2 program, 3 erase, 4 debugger read
   task automatic op(input int kind, input fbep_addr_t a, input fbep_data_t wd,
      output logic den, output fbep_data_t rd, output int lat);
      @(negedge core_clk);
      if_req = (kind == 0);
      if_addr = a;
      d_req = (kind == 1 || kind == 2 || kind == 4);
      d_write = (kind == 2);
      d_debug = (kind == 4);
      d_addr = a;
      d_wdata = wd;
      er_req = (kind == 3);
      er_block = a[15:10];
      // hold the request until a grant is seen, then let its edge pass
      for (int n = 0; n < 400; n++) begin
         #1;
         if ((if_gnt | d_gnt | er_gnt) === 1'b1) break;
         @(negedge core_clk);
      end
      check("grant", {29'h0, if_gnt, d_gnt, er_gnt}, (kind == 0) ? 4 : (kind == 3) ? 1 : 2);
      @(posedge core_clk);
      @(negedge core_clk);
      if_req = 1'b0;
      d_req = 1'b0;
      er_req = 1'b0;
      for (lat = 1; lat < 400; lat++) begin
         if (rsp_valid === 1'b1) break;
         @(negedge core_clk);
      end
      den = rsp_denied;
      rd = rsp_rdata;
      check("rsp_op", rsp_op, (kind == 4) ? 1 : kind);
   endtask : op

   task automatic xchk(input string name, input int kind, input fbep_addr_t a,
      input fbep_data_t wd, input logic eden, input fbep_data_t erd, input int elat);
      logic den;
      fbep_data_t rd;
      int lat;
      op(kind, a, wd, den, rd, lat);
      check({name, " denied"}, den, eden);
      check({name, " data"}, rd, erd);
      check({name, " latency"}, lat, elat);
   endtask : xchk

   task automatic set_attr(input fbep_region_t r, input fbep_attr_t at);
      @(negedge core_clk);
      prot_we = 1'b1;
      prot_region = r;
      prot_attr = at;
      @(negedge core_clk);
      prot_we = 1'b0;
   endtask : set_attr

   task automatic clear_viol();
      @(negedge core_clk);
      viol_clr = 1'b1;
      @(negedge core_clk);
      viol_clr = 1'b0;
      @(negedge core_clk);
      check("viol cleared", viol, 1'b0);
   endtask : clear_viol

   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_reset();
      check("viol after reset", viol, 1'b0);
      check("rsp_valid after reset", rsp_valid, 1'b0);
   endtask : s_reset

   // open region: program, read back, fetch another word
   task automatic s_open();
      xchk("prog open", 2, 16'h0C04, 32'h1234_5678, 1'b0, 32'h0, 3);
      xchk("read open", 1, 16'h0C04, 32'h0, 1'b0, 32'h1234_5678, 3);
      xchk("fetch open", 0, 16'h0808, 32'h0, 1'b0, pat(16'h0808), 3);
   endtask : s_open

   // erase block 2: all ones inside, neighbours untouched
   task automatic s_erase();
      int w0;
      w0 = flash.writes;
      xchk("erase blk", 3, 16'h0800, 32'h0, 1'b0, 32'h0, 258);
      check("erase writes", flash.writes - w0, 256);
      xchk("erased lo", 1, 16'h0800, 32'h0, 1'b0, `FBEP_ERASED, 3);
      xchk("erased hi", 1, 16'h0BFC, 32'h0, 1'b0, `FBEP_ERASED, 3);
      xchk("next blk", 1, 16'h0C04, 32'h0, 1'b0, 32'h1234_5678, 3);
      xchk("prev blk", 1, 16'h07FC, 32'h0, 1'b0, pat(16'h07FC), 3);
   endtask : s_erase

   // region 1 read-only: both blocks of the pair refuse change
   task automatic s_ro();
      set_attr(5'h01, `FBEP_ATTR_RO);
      xchk("ro prog", 2, 16'h0800, 32'h0000_1111, 1'b1, 32'h0, 2);
      check("viol set", viol, 1'b1);
      xchk("ro read", 1, 16'h0800, 32'h0, 1'b0, `FBEP_ERASED, 3);
      check("viol sticky", viol, 1'b1);
      clear_viol();
      xchk("ro erase pair", 3, 16'h0C00, 32'h0, 1'b1, 32'h0, 2);
      check("viol erase", viol, 1'b1);
      xchk("ro kept", 1, 16'h0C04, 32'h0, 1'b0, 32'h1234_5678, 3);
      xchk("ro debug", 4, 16'h0C04, 32'h0, 1'b0, 32'h1234_5678, 3);
      clear_viol();
   endtask : s_ro

   // regions 2 and 3 execute-only, codes 2 and 3
   task automatic s_xo();
      fbep_addr_t a;
      for (int r = 2; r < 4; r++) begin
         a = {r[4:0], 11'h010};
         set_attr(r[4:0], r[1:0]);
         xchk("xo read", 1, a, 32'h0, 1'b1, 32'h0, 2);
         xchk("xo debug", 4, a, 32'h0, 1'b1, 32'h0, 2);
         xchk("xo fetch", 0, a, 32'h0, 1'b0, pat(a), 3);
         xchk("xo prog", 2, a, 32'h0, 1'b1, 32'h0, 2);
         xchk("xo erase", 3, a, 32'h0, 1'b1, 32'h0, 2);
         xchk("xo kept", 0, a, 32'h0, 1'b0, pat(a), 3);
         clear_viol();
      end
   endtask : s_xo

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (16) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      s_reset();
      s_open();
      s_erase();
      s_ro();
      s_xo();
      end_sim();
   end
endmodule : tb
